// ===== logic/fbp_flash_block_protect.sv
// Flash block protection with program/erase sequencer and APB register slave
//
// The placing of the registers and the APB register port were left to the implementer.
`default_nettype none

module fbp_flash_block_protect
  import fbp_pkg::*;
#(
  parameter logic [15:0] PB_ADDR = 16'hfe00,
  parameter int ERASE_CYCLES = ERASE_CYCLES_DFLT,
  parameter int APB_ADDR_W = 8
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic por_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor low-power state and test pin
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic test_high_voltage,
  // Flash array controls
  output fbp_flash_ctl_t flash_ctl,
  output logic flash_standby
);

  // ========================================================================
  // Elaboration checks
  localparam int CNT_W = 16;

  // Refuse counts the duration counter cannot hold, before any run starts
  if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W)) begin : g_bad_erase
    $error("ERASE_CYCLES out of counter range");
  end
  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << CNT_W)) begin : g_bad_prog
    $error("PROG_CYCLES out of counter range");
  end
  if (APB_ADDR_W < 8) begin : g_bad_addr_w
    $error("APB_ADDR_W too narrow for the register map");
  end

  localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROG_CYCLES - 1);
  localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYCLES - 1);

  // ========================================================================
  // Declarations
  typedef enum logic [1:0] {
    S_IDLE,
    S_PROG,
    S_ERASE,
    S_STANDBY
  } fbp_state_t;

  fbp_state_t state_ff;
  fbp_state_t nxt_state;
  logic [15:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [1:0] op_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic refused_ff;
  logic aborted_ff;
  fbp_flash_ctl_t ctl_ff;
  logic [31:0] prdata_ff;
  logic [7:0] pb_q;
  logic [15:0] start_addr;
  logic req_refused;
  logic low_power;
  logic busy;
  logic wr_cycle;
  logic rd_cycle;
  logic addr_hit;
  logic cmd_wr;
  logic [1:0] cmd_op;
  logic start_ok;
  logic start_bad;
  logic op_done;
  logic abort;
  logic commit_prog;
  logic commit_erase;
  logic [APB_ADDR_W-1:0] reg_off;
  logic [31:0] nxt_prdata;

  // ========================================================================
  // APB decode: zero wait states, error on unmapped offsets
  assign reg_off = paddr;
  assign wr_cycle = psel & penable & pwrite;
  assign rd_cycle = psel & penable & ~pwrite;

  always_comb begin
    if (reg_off == APB_ADDR_W'(REG_CMD)) begin
      addr_hit = 1'b1;
    end else if (reg_off == APB_ADDR_W'(REG_ADDR)) begin
      addr_hit = 1'b1;
    end else if (reg_off == APB_ADDR_W'(REG_WDATA)) begin
      addr_hit = 1'b1;
    end else if (reg_off == APB_ADDR_W'(REG_STATUS)) begin
      addr_hit = 1'b1;
    end else if (reg_off == APB_ADDR_W'(REG_PROTECT)) begin
      addr_hit = 1'b1;
    end else if (reg_off == APB_ADDR_W'(REG_START)) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // ========================================================================
  // Command acceptance
  assign low_power = wait_mode | stop_mode;
  assign busy = (state_ff == S_PROG) || (state_ff == S_ERASE);
  assign cmd_wr = wr_cycle && (reg_off == APB_ADDR_W'(REG_CMD));
  assign cmd_op = pwdata[OP_W-1:0];
  // A command only starts from idle with the processor awake
  assign start_ok = cmd_wr && (state_ff == S_IDLE) && !low_power
                    && (fbp_op_t'(cmd_op) != OP_NONE) && !req_refused;
  assign start_bad = cmd_wr && (state_ff == S_IDLE) && !low_power
                     && (fbp_op_t'(cmd_op) != OP_NONE) && req_refused;

  // Checker judges the incoming command against the stored byte
  fbp_range_chk #(
    .PB_ADDR(PB_ADDR)
  ) u_chk (
    .op(cmd_op),
    .addr(addr_ff),
    .pb(pb_q),
    .bypass(test_high_voltage),
    .refused(req_refused),
    .start_addr(start_addr)
  );

  // ========================================================================
  // Sequencer
  assign op_done = busy && (cnt_ff == '0);
  assign abort = busy && low_power; // [RQ11] [RQ12]

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        // Reads carry on; a sleeping processor leaves the flash alone [RQ13]
        if (start_ok && fbp_op_t'(cmd_op) == OP_PROG) begin
          nxt_state = S_PROG;
        end else if (start_ok) begin
          nxt_state = S_ERASE;
        end
      end
      S_PROG, S_ERASE: begin
        if (abort) begin
          nxt_state = S_STANDBY; // [RQ11] [RQ12]
        end else if (op_done) begin
          nxt_state = S_IDLE;
        end
      end
      S_STANDBY: begin
        // Leave standby once the processor has woken up
        if (!low_power) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Duration counter, loaded on start
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (start_ok) begin
      cnt_ff <= (fbp_op_t'(cmd_op) == OP_PROG) ? PROG_LOAD : ERASE_LOAD;
    end else if (busy && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - CNT_W'(1);
    end
  end

  // Latched operation for the commit at the end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_ff <= OP_NONE;
    end else if (start_ok) begin
      op_ff <= cmd_op;
    end
  end

  // ========================================================================
  // Flash control outputs; refused requests never raise the high voltage
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_ff <= FLASH_CTL_IDLE;
    end else if (start_ok) begin
      ctl_ff.hv_en <= 1'b1; // [RQ15]
      ctl_ff.prog <= (fbp_op_t'(cmd_op) == OP_PROG);
      ctl_ff.erase <= (fbp_op_t'(cmd_op) == OP_PAGE_ERASE);
      ctl_ff.mass <= (fbp_op_t'(cmd_op) == OP_MASS_ERASE);
      ctl_ff.addr <= addr_ff;
      ctl_ff.wdata <= wdata_ff;
    end else if (abort || op_done) begin
      ctl_ff <= FLASH_CTL_IDLE; // All controls inactive [RQ14]
    end
  end

  assign flash_ctl = ctl_ff;
  assign flash_standby = (state_ff == S_STANDBY); // [RQ14]

  // ========================================================================
  // Protect byte: updated only when a real flash operation completes
  assign commit_prog = op_done && !abort && (fbp_op_t'(op_ff) == OP_PROG)
                       && (ctl_ff.addr == PB_ADDR); // [RQ7]
  assign commit_erase = op_done && !abort
                        && ((fbp_op_t'(op_ff) == OP_MASS_ERASE)
                            || ((fbp_op_t'(op_ff) == OP_PAGE_ERASE)
                                && fbp_same_page(ctl_ff.addr, PB_ADDR))); // [RQ6]

  fbp_nv_byte u_nv (
    .core_clk(core_clk),
    .por_rst(por_rst),
    .commit_prog(commit_prog),
    .commit_erase(commit_erase),
    .prog_data(ctl_ff.wdata),
    .pb_q(pb_q)
  );

  // ========================================================================
  // Software registers: target address and program data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_ff <= '0;
    end else if (wr_cycle && reg_off == APB_ADDR_W'(REG_ADDR)) begin
      addr_ff <= pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdata_ff <= '0;
    end else if (wr_cycle && reg_off == APB_ADDR_W'(REG_WDATA)) begin
      wdata_ff <= pwdata[7:0];
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      refused_ff <= 1'b0;
    end else if (start_bad) begin
      refused_ff <= 1'b1; // [RQ1] [RQ3] [RQ4]
    end else if (wr_cycle && reg_off == APB_ADDR_W'(REG_STATUS) && pwdata[ST_REFUSED]) begin
      refused_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aborted_ff <= 1'b0;
    end else if (abort) begin
      aborted_ff <= 1'b1; // [RQ11] [RQ12]
    end else if (wr_cycle && reg_off == APB_ADDR_W'(REG_STATUS) && pwdata[ST_ABORTED]) begin
      aborted_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Read mux; protect byte and start address are read-only views, so a
  // bus write to them is accepted and dropped [RQ7]
  always_comb begin
    nxt_prdata = '0;
    if (reg_off == APB_ADDR_W'(REG_ADDR)) begin
      nxt_prdata[15:0] = addr_ff;
    end else if (reg_off == APB_ADDR_W'(REG_WDATA)) begin
      nxt_prdata[7:0] = wdata_ff;
    end else if (reg_off == APB_ADDR_W'(REG_STATUS)) begin
      nxt_prdata[ST_BUSY] = busy;
      nxt_prdata[ST_REFUSED] = refused_ff;
      nxt_prdata[ST_ABORTED] = aborted_ff;
      nxt_prdata[ST_STANDBY] = (state_ff == S_STANDBY);
      nxt_prdata[ST_BYPASS] = test_high_voltage;
    end else if (reg_off == APB_ADDR_W'(REG_PROTECT)) begin
      nxt_prdata[7:0] = pb_q;
    end else if (reg_off == APB_ADDR_W'(REG_START)) begin
      nxt_prdata[15:0] = start_addr; // [RQ8]
    end else if (reg_off == APB_ADDR_W'(REG_CMD)) begin
      nxt_prdata[OP_W-1:0] = op_ff;
    end
  end

  // Read data is registered in the setup phase so it stands in the access phase
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_ff <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = rd_cycle ? prdata_ff : '0;

endmodule : fbp_flash_block_protect

`default_nettype wire

// ===== logic/fbp_nv_byte.sv
// Nonvolatile protect byte cell kept inside the flash array
`default_nettype none

module fbp_nv_byte
  import fbp_pkg::*;
(
  // Clock and power-on
  input wire logic core_clk,
  input wire logic por_rst,
  // Commit strobes from the sequencer
  input wire logic commit_prog,
  input wire logic commit_erase,
  input wire logic [7:0] prog_data,
  // Stored value
  output logic [7:0] pb_q
);

  // ========================================================================
  // Power-on and a permitted erase restore the factory value; the system reset is not wired
  // here at all, so it can never disturb the stored byte [RQ10]
  always_ff @(posedge core_clk or posedge por_rst) begin
    if (por_rst) begin
      pb_q <= PB_ERASED; // [RQ10]
    end else if (commit_erase) begin
      pb_q <= PB_ERASED; // [RQ6]
    end else if (commit_prog) begin
      pb_q <= pb_q & prog_data; // Programming only clears bits [RQ7]
    end
  end

endmodule : fbp_nv_byte

`default_nettype wire

// ===== logic/fbp_range_chk.sv
// Protection check of one program or erase request against the protect byte
`default_nettype none

module fbp_range_chk
  import fbp_pkg::*;
#(
  parameter logic [15:0] PB_ADDR = 16'hfe00
) (
  // Request
  input wire logic [1:0] op,
  input wire logic [15:0] addr,
  // Protection state
  input wire logic [7:0] pb,
  input wire logic bypass,
  // Verdict
  output logic refused,
  output logic [15:0] start_addr
);

  logic hits_range;
  logic hits_pb;

  // Start address from the protect bits [RQ8]
  assign start_addr = fbp_start_addr(pb); // [RQ8]

  // Range and protect byte hits; page erase is judged by its whole page
  always_comb begin
    hits_range = (addr >= start_addr); // Up to the top of memory [RQ9] [RQ15]
    hits_pb = (addr == PB_ADDR);
    if (fbp_op_t'(op) == OP_PAGE_ERASE) begin
      hits_range = (addr[ADDR_MSB:PAGE_LSB] >= start_addr[ADDR_MSB:PAGE_LSB]); // [RQ9]
      hits_pb = fbp_same_page(addr, PB_ADDR);
    end
  end

  // Verdict; the test voltage overrides all of it
  always_comb begin
    refused = 1'b0;
    if (bypass) begin
      refused = 1'b0; // [RQ5]
    end else if (pb == PB_ERASED) begin
      refused = 1'b0; // [RQ2]
    end else if (fbp_op_t'(op) == OP_MASS_ERASE) begin
      refused = 1'b1; // [RQ4]
    end else if (pb == PB_ALL_PROT) begin
      refused = 1'b1; // Whole array, including below the start [RQ1]
    end else begin
      refused = hits_range | hits_pb; // [RQ3] [RQ15]
    end
  end

endmodule : fbp_range_chk

`default_nettype wire

// ===== shared/fbp_pkg.sv
// Constants, types and helpers shared by the flash block protection logic
// ==========================================================================
// Function
// [RQ1] A protect byte of all zeros refuses every program and erase in the flash.
// [RQ2] A protect byte of all ones protects nothing and permits program and erase everywhere.
// [RQ3] A protect byte other than all ones blocks program or erase of itself and its range.
// [RQ4] Mass erase is refused whenever the protect byte is not all ones.
// [RQ5] The test high voltage on the interrupt pin bypasses all block protection.
// [RQ6] The protect byte is cleared to all ones by a permitted page or mass erase.
// [RQ7] The protect byte changes only by flash programming; bus writes to it do nothing.
// [RQ8] The start address is bit 15 one, bits 14 to 7 the protect bits, bits 6 to 0 zero.
// [RQ9] Protection covers the start address through the top of memory, on 128-byte steps.
// [RQ10] Reset leaves the protect byte unchanged; its factory value is all ones.
// [RQ11] Entering wait mode during program or erase aborts it and puts the flash in standby.
// [RQ12] Entering stop mode during program or erase aborts it and puts the flash in standby.
// [RQ13] Entering wait mode while the flash is only read leaves the flash undisturbed.
// [RQ14] In standby every internal flash control signal is held inactive.
// [RQ15] Each request compares its address with the start address and is suppressed at or above.
`default_nettype none

package fbp_pkg;

  // ========================================================================
  // Protect byte and address layout
  localparam logic [7:0] PB_ERASED = 8'hff;
  localparam logic [7:0] PB_ALL_PROT = 8'h00;
  localparam logic START_TOP_BIT = 1'b1;
  localparam logic [6:0] START_LOW_BITS = 7'h00;
  localparam int PAGE_LSB = 7;
  localparam int ADDR_MSB = 15;

  // ========================================================================
  // Register offsets (byte addresses) and status bit positions
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_PROTECT = 8'h10;
  localparam logic [7:0] REG_START = 8'h14;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_ABORTED = 2;
  localparam int ST_STANDBY = 3;
  localparam int ST_BYPASS = 4;
  localparam int OP_W = 2;

  // ========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 30000;
  localparam int ERASE_TIME_NS = 1000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DFLT = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ========================================================================
  // Types
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PROG = 2'h1,
    OP_PAGE_ERASE = 2'h2,
    OP_MASS_ERASE = 2'h3
  } fbp_op_t;

  typedef struct packed {
    logic hv_en;
    logic prog;
    logic erase;
    logic mass;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fbp_flash_ctl_t;

  localparam fbp_flash_ctl_t FLASH_CTL_IDLE = '0;

  // ========================================================================
  // Helpers
  function automatic logic [15:0] fbp_start_addr(input logic [7:0] pb);
    return {START_TOP_BIT, pb, START_LOW_BITS};
  endfunction : fbp_start_addr

  function automatic logic fbp_same_page(input logic [15:0] a, input logic [15:0] b);
    return a[ADDR_MSB:PAGE_LSB] == b[ADDR_MSB:PAGE_LSB];
  endfunction : fbp_same_page

endpackage : fbp_pkg

`default_nettype wire

// ===== verification/fbp_flash_block_protect_asserts.sv
// Port-level checker for the flash block protection block
`default_nettype none

module fbp_asserts
  import fbp_pkg::*;
#(
  parameter int ERASE_CYCLES = 20,
  parameter int APB_ADDR_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic pready,
  // Modes and flash controls
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire fbp_flash_ctl_t flash_ctl,
  input wire logic flash_standby
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Helper count
  logic [10:0] on_cnt_ff;

  // Cycles the current operation has been driven; cleared as soon as it drops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_cnt_ff <= 11'h000;
    end else begin
      on_cnt_ff <= flash_ctl.hv_en ? on_cnt_ff + 11'h001 : 11'h000;
    end
  end

  // ==========================================================================
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  standby_quiet_a: assert property (flash_standby |-> flash_ctl == FLASH_CTL_IDLE)
    else $error("flash controls active in standby");
  wait_abort_a: assert property (flash_ctl.hv_en && wait_mode |=>
    flash_ctl == FLASH_CTL_IDLE && flash_standby)
    else $error("wait did not abort the operation");
  stop_abort_a: assert property (flash_ctl.hv_en && stop_mode |=>
    flash_ctl == FLASH_CTL_IDLE && flash_standby)
    else $error("stop did not abort the operation");
  read_wait_a: assert property (wait_mode && !flash_ctl.hv_en && !flash_standby |=>
    !flash_standby)
    else $error("idle wait disturbed the flash");
  start_cause_a: assert property ($rose(flash_ctl.hv_en) |->
    $past(psel && penable && pwrite && paddr == REG_CMD && !wait_mode && !stop_mode))
    else $error("operation started without a command");
  op_hold_a: assert property (flash_ctl.hv_en && !wait_mode && !stop_mode &&
    int'(on_cnt_ff) < (flash_ctl.prog ? PROG_CYCLES : ERASE_CYCLES) - 2 |=> flash_ctl.hv_en)
    else $error("operation dropped early");
  op_end_a: assert property (flash_ctl.hv_en |->
    int'(on_cnt_ff) < (flash_ctl.prog ? PROG_CYCLES : ERASE_CYCLES))
    else $error("operation overran its time");
  ctl_stable_a: assert property (flash_ctl.hv_en && $past(flash_ctl.hv_en) |->
    $stable(flash_ctl))
    else $error("flash controls changed mid operation");
  standby_exit_a: assert property (flash_standby && !wait_mode && !stop_mode |->
    ##[1:3] !flash_standby)
    else $error("standby not left");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase stalled");
endmodule : fbp_asserts

bind fbp_flash_block_protect fbp_asserts #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .APB_ADDR_W(APB_ADDR_W)
) i_fbp_asserts (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pready(pready),
  .wait_mode(wait_mode),
  .stop_mode(stop_mode),
  .flash_ctl(flash_ctl),
  .flash_standby(flash_standby)
);

`default_nettype wire

// ===== verification/fbp_flash_model.sv
// Behavioural flash array driven by the block's control lines
`default_nettype none

module fbp_flash_model
  import fbp_pkg::*;
(
  // Clock and flash controls
  input wire logic core_clk,
  input wire fbp_flash_ctl_t flash_ctl,
  input wire logic flash_standby
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Upper half of the map only; cells start erased
  logic [7:0] mem [0:32767];
  fbp_flash_ctl_t last_ff = FLASH_CTL_IDLE;

  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'hff;
    end
  end

  // Commit when an operation ends; an aborted one leaves the cells untouched
  always @(posedge core_clk) begin
    last_ff <= flash_ctl;
    if (last_ff.hv_en && !flash_ctl.hv_en && !flash_standby) begin
      if (last_ff.mass) begin
        for (int i = 0; i < 32768; i++) begin
          mem[i] = 8'hff;
        end
      end else if (last_ff.prog) begin
        mem[last_ff.addr[14:0]] = mem[last_ff.addr[14:0]] & last_ff.wdata;
      end else begin
        for (int i = 0; i < 128; i++) begin
          mem[{last_ff.addr[14:7], 7'h00} + 15'(i)] = 8'hff;
        end
      end
    end
  end
endmodule : fbp_flash_model

`default_nettype wire

// ===== verification/tb_flash_block_protect.sv
// Self-checking bench for the flash block protection block
`default_nettype none

module tb_flash_block_protect
  import fbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Stimulus and observed signals
  localparam logic [15:0] PB_LOC = 16'hfe00;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic por_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic test_high_voltage = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fbp_flash_ctl_t flash_ctl;
  logic flash_standby;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  // Clock
  always #25 core_clk = ~core_clk;

  fbp_flash_block_protect #(.PB_ADDR(PB_LOC), .ERASE_CYCLES(20)) i_fbp_flash_block_protect (
    .core_clk(core_clk), .sys_rst(sys_rst), .por_rst(por_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .test_high_voltage(test_high_voltage), .flash_ctl(flash_ctl),
    .flash_standby(flash_standby)
  );

  fbp_flash_model i_fbp_flash_model (
    .core_clk(core_clk), .flash_ctl(flash_ctl), .flash_standby(flash_standby)
  );

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; held until pready is seen at an access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rd_reg

  // Issue a command; a refused one must raise the refused flag, which is then cleared
  task automatic do_op(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
                       input logic ok);
    apb(1'b1, REG_ADDR, {16'h0, a});
    apb(1'b1, REG_WDATA, {24'h0, d});
    apb(1'b1, REG_CMD, {30'h0, op});
    @(posedge core_clk);
    #1;
    chk(flash_ctl.hv_en, ok, "op start");
    if (ok) begin
      chk({flash_ctl.addr, flash_ctl.wdata}, {a, d}, "op target");
      chk({flash_ctl.prog, flash_ctl.erase, flash_ctl.mass},
          {op == OP_PROG, op == OP_PAGE_ERASE, op == OP_MASS_ERASE}, "op kind");
    end else begin
      rd_reg(REG_STATUS, 32'h2, "refused flag");
      apb(1'b1, REG_STATUS, 32'h2);
    end
  endtask : do_op

  task automatic wait_idle();
    while (flash_ctl.hv_en !== 1'b0) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
  endtask : wait_idle

  // ==========================================================================
  // Scenarios
  task automatic s_reset();
    rd_reg(REG_PROTECT, 32'hff, "factory byte");
    rd_reg(REG_START, 32'hff80, "start addr");
    apb(1'b1, REG_PROTECT, 32'h0);
    rd_reg(REG_PROTECT, 32'hff, "bus write");
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1, "unmapped");
  endtask : s_reset

  task automatic s_open();
    do_op(OP_PROG, 16'h8000, 8'ha5, 1'b1);
    wait_idle();
    chk(i_fbp_flash_model.mem[0], 8'ha5, "model byte");
    do_op(OP_PAGE_ERASE, 16'hff80, 8'h00, 1'b1);
    wait_idle();
    do_op(OP_MASS_ERASE, 16'h8000, 8'h00, 1'b1);
    wait_idle();
  endtask : s_open

  // Protect from 8100 up, probe both sides of the boundary, abort by wait
  task automatic s_range();
    do_op(OP_PROG, PB_LOC, 8'h02, 1'b1);
    wait_idle();
    rd_reg(REG_START, 32'h8100, "start");
    do_op(OP_PROG, 16'h8100, 8'h00, 1'b0);
    do_op(OP_PAGE_ERASE, 16'hfff0, 8'h00, 1'b0);
    do_op(OP_PROG, PB_LOC, 8'h00, 1'b0);
    do_op(OP_MASS_ERASE, 16'h8000, 8'h00, 1'b0);
    do_op(OP_PROG, 16'h80ff, 8'h3c, 1'b1);
    @(posedge core_clk);
    wait_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({flash_ctl.hv_en, flash_standby}, 2'b01, "wait abort");
    rd_reg(REG_STATUS, 32'hc, "abort status");
    wait_mode <= 1'b0;
    // Clear the sticky abort so later refused-flag reads see only bit 1
    apb(1'b1, REG_STATUS, 32'h4);
    repeat (4) @(posedge core_clk);
    chk(i_fbp_flash_model.mem[255], 8'hff, "aborted byte");
  endtask : s_range

  task automatic s_bypass();
    @(posedge core_clk);
    test_high_voltage <= 1'b1;
    do_op(OP_PAGE_ERASE, PB_LOC, 8'h00, 1'b1);
    wait_idle();
    rd_reg(REG_PROTECT, 32'hff, "byte erased");
    test_high_voltage <= 1'b0;
  endtask : s_bypass

  // All zeros locks everything and survives a system reset
  task automatic s_all();
    do_op(OP_PROG, PB_LOC, 8'h00, 1'b1);
    wait_idle();
    do_op(OP_PROG, 16'h8000, 8'h00, 1'b0);
    do_op(OP_PAGE_ERASE, 16'h8000, 8'h00, 1'b0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_reg(REG_PROTECT, 32'h0, "byte after reset");
    test_high_voltage <= 1'b1;
    do_op(OP_MASS_ERASE, 16'h8000, 8'h00, 1'b1);
    wait_idle();
    rd_reg(REG_PROTECT, 32'hff, "mass cleared");
    test_high_voltage <= 1'b0;
  endtask : s_all

  task automatic s_stop();
    do_op(OP_PAGE_ERASE, 16'h8000, 8'h00, 1'b1);
    @(posedge core_clk);
    stop_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({flash_ctl.hv_en, flash_standby}, 2'b01, "stop abort");
    @(posedge core_clk);
    stop_mode <= 1'b0;
    // Standby is only left with both modes low; enter wait from idle
    repeat (2) @(posedge core_clk);
    wait_mode <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk(flash_standby, 1'b0, "idle wait");
    @(posedge core_clk);
    wait_mode <= 1'b0;
  endtask : s_stop

  // ==========================================================================
  // Verdict and hang guard
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // About 2100 cycles are needed; the ceiling leaves ample room
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      stop_test();
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    s_reset();
    s_open();
    s_range();
    s_bypass();
    s_all();
    s_stop();
    stop_test();
  end
endmodule : tb_flash_block_protect

`default_nettype wire
